// ==== design/axis_cassette_service_diag.sv ====
`timescale 1ns/1ps
`include "cassette_regs.svh"

// Behaviour
// - programming stores preset one/two, axes 1-4
// - programming reply echoes low three value bytes
// - output data four bytes/29 bits (preset 30) or two/14
// - command bit clear means ongoing preset request
// - preset only on rising edge of bit 31
// - preset result message, alarm B6 clear if good
// - display top bit is sign, negative output
// - display range limits, overflow shows six digits
// - three bytes per display axis, max eight
// - bits below sign flag out of range
// - poll sends 16 or 62 byte message
// - new error sends message with bytes 7, 11
// - error numbers only on poll, poll acknowledges
// - all acknowledged clears alarms, status, error flag
// - each completed special service sends confirmation
// - alarm byte 7 bit assignments
// - status byte 8 bit assignments
// - type byte 9 encoder or cassette code
// - axis byte 10: cassette, axis, preset 80
// - byte 11 one pending-error flag per axis
// - check-back fields carry error pairs or echo
// - reset-all clears every source; else named axis
module axis_cassette_service_diag #(
    parameter int DISP_AXES = 8,
    parameter int ERR_DEPTH = 4,
    parameter logic [7:0] CASSETTE_TYPE_CODE = 8'h3c // arbitrary value
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic ERR_STROBE,
    input wire logic [3:0] ERR_SOURCE,
    input wire logic [15:0] ERR_CODE,
    input wire logic [7:0] ERR_ALARM,
    output logic DIAG_READY,
    output logic [7:0] DIAG_LENGTH,
    output logic PRESET_STROBE,
    output logic [2:0] PRESET_AXIS,
    output logic [29:0] PRESET_VALUE,
    output logic PRESET_SELECT,
    output logic PROG_STROBE,
    output logic [2:0] PROG_AXIS,
    output logic PROG_SLOT,
    output logic [28:0] PROG_VALUE,
    output logic [7:0] POS_ERR_FLAG,
    output logic CASSETTE_ERR,
    output logic OP_ERR_STATUS,
    output logic [DISP_AXES-1:0] DISPLAY_SIGN_FLAG,
    output logic [DISP_AXES-1:0] DISPLAY_RANGE_ERR,
    output logic [DISP_AXES*20-1:0] DISPLAY_MAGNITUDE_BITS
);

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    logic wr_go;
    logic rd_setup;
    logic addr_ok;
    logic [31:0] rd_word;
    cassette_pkg::svc_ctrl_type svc;
    logic [31:0] out_data;
    logic [31:0] config_reg;
    logic [23:0] disp_word [0:DISP_AXES-1];
    logic [7:0] frame [0:63];
    logic [8:0] pending;
    logic svc_go;
    logic diag_ack;

    // one wait state: the answer is prepared during the first access cycle
    assign rd_setup = PSEL && PENABLE && !PREADY;
    assign wr_go = PSEL && PENABLE && PREADY && PWRITE;

    always_comb begin
        rd_word = 32'h0000_0000;
        addr_ok = 1'b1;
        if (PADDR >= `FRAME_BASE_OFS && !PADDR[7] && PADDR[1:0] == 2'b00) begin
            rd_word = {frame[{PADDR[5:2], 2'b11}], frame[{PADDR[5:2], 2'b10}],
                       frame[{PADDR[5:2], 2'b01}], frame[{PADDR[5:2], 2'b00}]};
        end else if (PADDR >= `DISP_BASE_OFS && PADDR < `FRAME_BASE_OFS && PADDR[1:0] == 2'b00
                     && 32'(PADDR[4:2]) < DISP_AXES) begin
            rd_word = {8'h00, disp_word[PADDR[4:2]]};
        end else begin
            case (PADDR)
                `SVC_CTRL_OFS: rd_word = {16'h0000, svc};
                `OUT_DATA_OFS: rd_word = out_data;
                `CONFIG_OFS: rd_word = config_reg;
                `DIAG_STAT_OFS: rd_word = {16'h0000, DIAG_LENGTH, 7'h00, DIAG_READY};
                `ERR_SUM_OFS: rd_word = {22'h000000, OP_ERR_STATUS, pending};
                default: addr_ok = 1'b0;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= rd_setup;
            PSLVERR <= rd_setup && !addr_ok;
            if (rd_setup) begin
                PRDATA <= (PWRITE || !addr_ok) ? 32'h0000_0000 : rd_word;
            end
        end
    end

    // ----------------------------------------
    // writable registers
    // ----------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            svc <= '0;
            out_data <= 32'h0000_0000;
            config_reg <= `CONFIG_RESET;
            svc_go <= 1'b0;
            diag_ack <= 1'b0;
        end else begin
            svc_go <= wr_go && PADDR == `SVC_CTRL_OFS;
            diag_ack <= wr_go && PADDR == `DIAG_STAT_OFS && PWDATA[0];
            if (wr_go && PADDR == `SVC_CTRL_OFS) begin
                svc <= cassette_pkg::svc_ctrl_type'(PWDATA[15:0]);
            end
            if (wr_go && PADDR == `OUT_DATA_OFS) begin
                out_data <= PWDATA;
            end
            if (wr_go && PADDR == `CONFIG_OFS) begin
                config_reg <= {16'h0000, PWDATA[15:0]};
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DISP_AXES; gi++) begin : g_disp
            logic [23:0] w;
            logic beyond;
            assign w = disp_word[gi];
            // beyond the printable span the display drops leading digits
            assign beyond = w[23] ? (w[19:0] > `DISP_NEG_MAX) : (w[19:0] > `DISP_POS_MAX);
            always_ff @(posedge CLK or negedge rst_n) begin
                if (!rst_n) begin
                    disp_word[gi] <= 24'h000000;
                    DISPLAY_SIGN_FLAG[gi] <= 1'b0;
                    DISPLAY_RANGE_ERR[gi] <= 1'b0;
                    DISPLAY_MAGNITUDE_BITS[gi*20 +: 20] <= 20'h00000;
                end else begin
                    if (wr_go && PADDR == 8'(`DISP_BASE_OFS + 4 * gi)) begin
                        disp_word[gi] <= PWDATA[23:0];
                    end
                    DISPLAY_SIGN_FLAG[gi] <= w[23];
                    DISPLAY_RANGE_ERR[gi] <= (|w[22:20]) || beyond;
                    DISPLAY_MAGNITUDE_BITS[gi*20 +: 20] <= w[19:0];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // service decode
    // ----------------------------------------
    logic two_byte;
    logic long_cfg;
    logic axis_prog_ok;
    logic svc_conflict;
    logic prog_num_ok;
    logic [28:0] prog_val;
    logic [29:0] preset_val;
    logic preset_prev;
    logic preset_go;
    logic poll_go;
    logic reset_go;
    logic [8:0] poll_mask;

    assign two_byte = config_reg[`CFG_TWO_BYTE_BIT];
    assign long_cfg = config_reg[`CFG_LONG_BIT];
    assign axis_prog_ok = svc.axis != 8'h00 && svc.axis <= {4'h0, `PROG_AXIS_MAX};
    assign svc_conflict = svc.num.prog && svc.num.special;
    assign prog_num_ok = svc.num[5:0] == 6'd1 || svc.num[5:0] == 6'd2;
    assign prog_val = two_byte ? {15'h0000, out_data[`PROG_BITS_TWO-1:0]} : out_data[`PROG_BITS_FOUR-1:0];
    assign preset_val = two_byte ? {16'h0000, out_data[`PROG_BITS_TWO-1:0]} : out_data[`PRESET_BITS-1:0];
    assign preset_go = out_data[31] && !preset_prev && !svc.num.prog;
    assign poll_go = svc_go && !svc_conflict && svc.num.special && svc.num.poll;
    assign reset_go = svc_go && !svc_conflict && svc.num.special && svc.num.reset_all;
    assign poll_mask = (svc.axis <= {4'h0, `ERR_SRC_MAX}) ? 9'(9'h001 << svc.axis[3:0]) : 9'h000;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            preset_prev <= 1'b0;
            PRESET_STROBE <= 1'b0;
            PRESET_AXIS <= 3'h0;
            PRESET_VALUE <= 30'h00000000;
            PRESET_SELECT <= 1'b0;
            PROG_STROBE <= 1'b0;
            PROG_AXIS <= 3'h0;
            PROG_SLOT <= 1'b0;
            PROG_VALUE <= 29'h00000000;
        end else begin
            preset_prev <= out_data[31];
            PRESET_STROBE <= preset_go && axis_prog_ok;
            if (preset_go && axis_prog_ok) begin
                PRESET_AXIS <= svc.axis[2:0];
                PRESET_VALUE <= preset_val;
            end
            if (svc_go && svc.num.special && !svc_conflict) begin
                PRESET_SELECT <= svc.num.preset_sel;
            end
            PROG_STROBE <= svc_go && svc.num.prog && !svc_conflict && axis_prog_ok && prog_num_ok;
            if (svc_go && svc.num.prog && !svc_conflict && axis_prog_ok && prog_num_ok) begin
                PROG_AXIS <= svc.axis[2:0];
                PROG_SLOT <= !svc.num.poll;
                PROG_VALUE <= prog_val;
            end
        end
    end

    // ----------------------------------------
    // error store
    // ----------------------------------------
    logic [15:0] err_code [0:8][0:ERR_DEPTH-1];
    logic [8:0] clr_mask;
    logic [8:0] set_mask;
    logic [7:0] alarm_sticky;
    logic err_due;
    logic src_ok;

    assign src_ok = ERR_SOURCE <= `ERR_SRC_MAX;
    assign set_mask = (ERR_STROBE && src_ok) ? 9'(9'h001 << ERR_SOURCE) : 9'h000;
    assign clr_mask = reset_go ? 9'h1ff : (poll_go ? poll_mask : 9'h000);

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pending <= 9'h000;
            for (int s = 0; s < 9; s++) begin
                for (int d = 0; d < ERR_DEPTH; d++) begin
                    err_code[s][d] <= 16'h0000;
                end
            end
        end else begin
            // a new error wins over an acknowledge in the same cycle
            pending <= (pending & ~clr_mask) | set_mask;
            for (int s = 0; s < 9; s++) begin
                if (set_mask[s]) begin
                    err_code[s][0] <= ERR_CODE;
                    for (int d = 1; d < ERR_DEPTH; d++) begin
                        err_code[s][d] <= clr_mask[s] ? 16'h0000 : err_code[s][d-1];
                    end
                end else if (clr_mask[s]) begin
                    for (int d = 0; d < ERR_DEPTH; d++) begin
                        err_code[s][d] <= 16'h0000;
                    end
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            alarm_sticky <= 8'h00;
            POS_ERR_FLAG <= 8'h00;
            CASSETTE_ERR <= 1'b0;
            OP_ERR_STATUS <= 1'b0;
        end else begin
            if (ERR_STROBE && src_ok) begin
                alarm_sticky <= alarm_sticky | ERR_ALARM;
            end else if (pending == 9'h000) begin
                alarm_sticky <= 8'h00;
            end
            POS_ERR_FLAG <= pending[8:1];
            CASSETTE_ERR <= pending[0];
            OP_ERR_STATUS <= |pending;
        end
    end

    // ----------------------------------------
    // diagnostic message builder
    // ----------------------------------------
    cassette_pkg::diag_kind_type kind;
    logic [7:0] alarm_now;
    logic [7:0] status_now;
    logic [7:0] len_now;

    always_comb begin
        if (svc_go && (svc_conflict || !(svc.num.prog || svc.num.special))) begin
            kind = cassette_pkg::DIAG_BADSVC;
        end else if (svc_go && svc.num.prog) begin
            kind = cassette_pkg::DIAG_PROG;
        end else if (svc_go) begin
            kind = cassette_pkg::DIAG_SPECIAL;
        end else if (preset_go) begin
            kind = cassette_pkg::DIAG_PRESET;
        end else if (err_due) begin
            kind = cassette_pkg::DIAG_ERR;
        end else begin
            kind = cassette_pkg::DIAG_NONE;
        end
    end

    assign len_now = (kind == cassette_pkg::DIAG_SPECIAL && svc.num.poll && long_cfg)
                     ? `LONG_DIAG_LEN : `SHORT_DIAG_LEN;
    assign status_now = {config_reg[`CFG_PROG_MODE_BIT], 1'b1, 2'b00, config_reg[`CFG_SCALING_BIT],
                         config_reg[`CFG_COMMISSION_BIT], long_cfg, 1'b0};

    always_comb begin
        alarm_now = alarm_sticky;
        case (kind)
            cassette_pkg::DIAG_BADSVC: alarm_now[`ALARM_SVC_BIT] = 1'b1;
            cassette_pkg::DIAG_PROG: alarm_now[`ALARM_PROG_BIT] = !(axis_prog_ok && prog_num_ok);
            cassette_pkg::DIAG_PRESET: alarm_now[`ALARM_PROG_BIT] = !axis_prog_ok;
            default: ;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            err_due <= 1'b0;
            DIAG_READY <= 1'b0;
            DIAG_LENGTH <= `SHORT_DIAG_LEN;
            for (int b = 0; b < 64; b++) begin
                frame[b] <= 8'h00;
            end
        end else begin
            // a fresh error keeps its message due even while one is sent
            err_due <= (|(set_mask & ~pending)) || (err_due && kind != cassette_pkg::DIAG_ERR);
            DIAG_READY <= (kind != cassette_pkg::DIAG_NONE) || (DIAG_READY && !diag_ack);
            if (kind != cassette_pkg::DIAG_NONE) begin
                DIAG_LENGTH <= len_now;
                // standard bytes 0..5 belong to the fieldbus layer, kept zero here
                for (int b = 0; b < 64; b++) begin
                    frame[b] <= 8'h00;
                end
                frame[`DIAG_HDR_OFS] <= 8'(len_now - 8'(`STD_DIAG_BYTES));
                frame[`DIAG_ALARM_OFS] <= alarm_now;
                frame[`DIAG_STAT_OFS_B] <= status_now;
                frame[`DIAG_TYPE_OFS] <= config_reg[15:8] == 8'h00 ? CASSETTE_TYPE_CODE : config_reg[15:8];
                frame[`DIAG_PEND_OFS] <= pending[8:1];
                case (kind)
                    cassette_pkg::DIAG_PRESET: begin
                        frame[`DIAG_AXIS_OFS] <= `AXIS_PRESET_DONE;
                    end
                    cassette_pkg::DIAG_PROG: begin
                        frame[`DIAG_AXIS_OFS] <= svc.axis;
                        frame[`DIAG_CHECK_OFS] <= svc.num;
                        frame[`DIAG_CHECK_OFS+1] <= 8'(prog_val[28:16]);
                        frame[`DIAG_CHECK_OFS+2] <= prog_val[15:8];
                        frame[`DIAG_CHECK_OFS+3] <= prog_val[7:0];
                    end
                    cassette_pkg::DIAG_SPECIAL, cassette_pkg::DIAG_BADSVC: begin
                        frame[`DIAG_AXIS_OFS] <= svc.axis;
                        frame[`DIAG_CHECK_OFS] <= svc.num;
                        if (svc.num.poll && svc.axis <= {4'h0, `ERR_SRC_MAX}
                            && kind == cassette_pkg::DIAG_SPECIAL) begin
                            // short frame has room for two pairs only
                            for (int d = 0; d < ERR_DEPTH; d++) begin
                                if (long_cfg || d < 2) begin
                                    frame[`DIAG_CHECK_OFS+2*d] <= err_code[svc.axis[3:0]][d][15:8];
                                    frame[`DIAG_CHECK_OFS+2*d+1] <= err_code[svc.axis[3:0]][d][7:0];
                                end
                            end
                        end
                    end
                    default: begin
                        frame[`DIAG_AXIS_OFS] <= `AXIS_CASSETTE;
                    end
                endcase
            end
        end
    end

endmodule

// ==== design/cassette_regs.svh ====
`ifndef CASSETTE_REGS_SVH
`define CASSETTE_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SVC_CTRL_OFS 8'h00
`define OUT_DATA_OFS 8'h04
`define CONFIG_OFS 8'h08
`define DIAG_STAT_OFS 8'h0c
`define ERR_SUM_OFS 8'h10
`define DISP_BASE_OFS 8'h20
`define FRAME_BASE_OFS 8'h40

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CFG_LONG_BIT 0
`define CFG_TWO_BYTE_BIT 1
`define CFG_COMMISSION_BIT 2
`define CFG_SCALING_BIT 3
`define CFG_PROG_MODE_BIT 4
`define CONFIG_RESET 32'h0000_0000
`define ALARM_MEAS_BIT 0
`define ALARM_SVC_BIT 5
`define ALARM_PROG_BIT 6
`define ALARM_VERIFY_BIT 7
`define STAT_CLASS_BIT 1
`define STAT_COMMISSION_BIT 2
`define STAT_SCALING_BIT 3
`define STAT_FUNC_BIT 6
`define STAT_PROG_BIT 7

// ----------------------------------------
// diagnostic frame layout
// ----------------------------------------
`define STD_DIAG_BYTES 6
`define SHORT_DIAG_LEN 8'd16
`define LONG_DIAG_LEN 8'd62
`define DIAG_HDR_OFS 6
`define DIAG_ALARM_OFS 7
`define DIAG_STAT_OFS_B 8
`define DIAG_TYPE_OFS 9
`define DIAG_AXIS_OFS 10
`define DIAG_PEND_OFS 11
`define DIAG_CHECK_OFS 12
`define AXIS_PRESET_DONE 8'h80
`define AXIS_CASSETTE 8'h00
`define PROG_AXIS_MAX 4'd4
`define ERR_SRC_MAX 4'd8
`define PROG_BITS_FOUR 29
`define PROG_BITS_TWO 14
`define PRESET_BITS 30

// ----------------------------------------
// display word limits
// ----------------------------------------
`define DISP_POS_MAX 20'hf423f
`define DISP_NEG_MAX 20'h1869f

`endif

// ==== design/cassette_pkg.sv ====
package cassette_pkg;

    typedef struct packed {
        logic prog;
        logic special;
        logic preset_sel;
        logic [1:0] spare;
        logic velocity;
        logic reset_all;
        logic poll;
    } svc_num_type;

    typedef struct packed {
        logic [7:0] axis;
        svc_num_type num;
    } svc_ctrl_type;

    typedef enum logic [2:0] {
        DIAG_NONE = 3'b000,
        DIAG_ERR = 3'b001,
        DIAG_SPECIAL = 3'b010,
        DIAG_PROG = 3'b011,
        DIAG_PRESET = 3'b100,
        DIAG_BADSVC = 3'b101
    } diag_kind_type;

endpackage

// ==== tb/axis_checker.sv ====
`timescale 1ns/1ps
module axis_checker (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic ERR_STROBE,
    input wire logic [3:0] ERR_SOURCE,
    input wire logic DIAG_READY,
    input wire logic [7:0] DIAG_LENGTH,
    input wire logic PRESET_STROBE,
    input wire logic [2:0] PRESET_AXIS,
    input wire logic PROG_STROBE,
    input wire logic [2:0] PROG_AXIS,
    input wire logic [7:0] POS_ERR_FLAG,
    input wire logic CASSETTE_ERR,
    input wire logic OP_ERR_STATUS
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    // ----------------------------------------
    // bus and command checks
    // ----------------------------------------
    property p_ready_wait;
        PSEL && PENABLE && !$past(PENABLE) |=> PREADY ##1 !PREADY;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready not after one wait state");
    property p_preset_once;
        PRESET_STROBE |=> !PRESET_STROBE;
    endproperty
    a_preset_once: assert property (p_preset_once) else $error("preset strobe repeated");
    property p_preset_axis;
        PRESET_STROBE |-> PRESET_AXIS inside {[3'd1:3'd4]};
    endproperty
    a_preset_axis: assert property (p_preset_axis) else $error("preset on bad axis");
    property p_prog_axis;
        PROG_STROBE |-> PROG_AXIS inside {[3'd1:3'd4]};
    endproperty
    a_prog_axis: assert property (p_prog_axis) else $error("program on bad axis");
    property p_diag_len;
        DIAG_LENGTH == 8'd16 || DIAG_LENGTH == 8'd62;
    endproperty
    a_diag_len: assert property (p_diag_len) else $error("bad diagnostic length");
    // ----------------------------------------
    // error bookkeeping
    // ----------------------------------------
    property p_op_status;
        OP_ERR_STATUS == ((|POS_ERR_FLAG) || CASSETTE_ERR);
    endproperty
    a_op_status: assert property (p_op_status) else $error("error status disagrees");
    property p_err_flag;
        ERR_STROBE && ERR_SOURCE inside {[4'd1:4'd8]} |-> ##[1:3] POS_ERR_FLAG != 8'h00;
    endproperty
    a_err_flag: assert property (p_err_flag) else $error("axis error not flagged");
    property p_cass_err;
        ERR_STROBE && ERR_SOURCE == 4'd0 |-> ##[1:3] CASSETTE_ERR;
    endproperty
    a_cass_err: assert property (p_cass_err) else $error("cassette error not flagged");
    property p_err_msg;
        ERR_STROBE && ERR_SOURCE == 4'd0 && !CASSETTE_ERR && !PSEL |-> ##[1:3] DIAG_READY;
    endproperty
    a_err_msg: assert property (p_err_msg) else $error("no message for new error");
endmodule

bind axis_cassette_service_diag axis_checker u_axis_checker (.CLK, .RST_N, .PSEL, .PENABLE, .PREADY,
    .ERR_STROBE, .ERR_SOURCE, .DIAG_READY, .DIAG_LENGTH, .PRESET_STROBE, .PRESET_AXIS, .PROG_STROBE,
    .PROG_AXIS, .POS_ERR_FLAG, .CASSETTE_ERR, .OP_ERR_STATUS);

// ==== tb/apb_master_model.sv ====
`timescale 1ns/1ps
`include "cassette_regs.svh"
module apb_master_model (
    input wire logic clk,
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [7:0] paddr = 8'h00,
    output logic [31:0] pwdata = 32'h0,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic sel = 1'b0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data must not look valid
        pwdata <= ~d;
    endtask
    // preset choice rides along with every special service
    task automatic special(input logic [7:0] ax, input logic [4:0] b);
        logic [31:0] r;
        logic e;
        xfer(1'b1, `SVC_CTRL_OFS, {16'h0, ax, 2'b01, sel, b}, r, e);
    endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "cassette_regs.svh"
module tb_top;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic ERR_STROBE = 1'b0;
    logic [3:0] ERR_SOURCE = 4'h0;
    logic [15:0] ERR_CODE = 16'h0;
    logic [7:0] ERR_ALARM = 8'h00;
    logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, DIAG_READY, PRESET_STROBE, PRESET_SELECT;
    logic PROG_STROBE, PROG_SLOT, CASSETTE_ERR, OP_ERR_STATUS;
    logic [7:0] PADDR, DIAG_LENGTH, POS_ERR_FLAG, DISPLAY_SIGN_FLAG, DISPLAY_RANGE_ERR;
    logic [31:0] PWDATA, PRDATA;
    logic [2:0] PRESET_AXIS, PROG_AXIS;
    logic [29:0] PRESET_VALUE;
    logic [28:0] PROG_VALUE;
    logic [159:0] DISPLAY_MAGNITUDE_BITS;
    logic [23:0] dw [4] = '{24'h81869f, 24'h8186a0, 24'h100000, 24'h0f423f};
    int fails = 0;
    int n_compared = 0;
    int n_preset = 0;
    int n_prog = 0;
    axis_cassette_service_diag u_axis_cassette_service_diag (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE,
        .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .ERR_STROBE, .ERR_SOURCE, .ERR_CODE, .ERR_ALARM,
        .DIAG_READY, .DIAG_LENGTH, .PRESET_STROBE, .PRESET_AXIS, .PRESET_VALUE, .PRESET_SELECT,
        .PROG_STROBE, .PROG_AXIS, .PROG_SLOT, .PROG_VALUE, .POS_ERR_FLAG, .CASSETTE_ERR, .OP_ERR_STATUS,
        .DISPLAY_SIGN_FLAG, .DISPLAY_RANGE_ERR, .DISPLAY_MAGNITUDE_BITS);
    apb_master_model u_apb_master_model (.clk(CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
        .paddr(PADDR), .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask
    // settle time covers the two-cycle lag of derived outputs
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        u_apb_master_model.xfer(1'b1, a, d, r, e);
        repeat (3) @(posedge CLK);
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        logic s;
        u_apb_master_model.xfer(1'b0, a, 32'h0, r, s);
        chk(n, e, r & m);
    endtask
    task automatic sp(input logic [7:0] ax, input logic [4:0] b);
        wr(`DIAG_STAT_OFS, 32'h1);
        u_apb_master_model.special(ax, b);
        repeat (3) @(posedge CLK);
    endtask
    task automatic err(input logic [3:0] s);
        @(posedge CLK);
        ERR_STROBE <= 1'b1;
        ERR_SOURCE <= s;
        ERR_CODE <= {4'h0, s, 8'h5a};
        ERR_ALARM <= 8'h01;
        @(posedge CLK);
        ERR_STROBE <= 1'b0;
        repeat (3) @(posedge CLK);
    endtask
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        forever #12.5 CLK = ~CLK;
    end
    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        test_done;
    end
    always @(posedge CLK) begin
        if (PRESET_STROBE === 1'b1) n_preset++;
        if (PROG_STROBE === 1'b1) n_prog++;
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        logic [31:0] rd;
        logic se;
        repeat (5) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (5) @(posedge CLK);
        chk("diag_length", 32'd16, {24'h0, DIAG_LENGTH});
        rc("config", `CONFIG_OFS, 32'hffffffff, `CONFIG_RESET);
        u_apb_master_model.xfer(1'b0, 8'h80, 32'h0, rd, se);
        chk("unmapped", 32'h1, {31'h0, se});
        wr(`DIAG_STAT_OFS, 32'h1);
        err(4'd2);
        chk("diag_ready", 32'h1, {31'h0, DIAG_READY});
        rc("frame4", 8'h44, 32'hffff0000, 32'h010a0000);
        rc("frame8", 8'h48, 32'hffffffff, 32'h02003c40);
        rc("frame12", 8'h4c, 32'hffffffff, 32'h0);
        sp(8'd2, 5'h01);
        chk("errs", 32'h0, {22'h0, POS_ERR_FLAG, CASSETTE_ERR, OP_ERR_STATUS});
        chk("diag_ready", 32'h1, {31'h0, DIAG_READY});
        rc("frame8", 8'h48, 32'h00ff0000, 32'h00020000);
        err(4'd0);
        err(4'd5);
        chk("errs", 32'h043, {22'h0, POS_ERR_FLAG, CASSETTE_ERR, OP_ERR_STATUS});
        sp(8'd0, 5'h02);
        chk("errs", 32'h0, {22'h0, POS_ERR_FLAG, CASSETTE_ERR, OP_ERR_STATUS});
        wr(`CONFIG_OFS, 32'h1);
        err(4'd3);
        sp(8'd3, 5'h01);
        chk("diag_length", 32'd62, {24'h0, DIAG_LENGTH});
        rc("frame4", 8'h44, 32'h00ff0000, 32'h00380000);
        u_apb_master_model.sel = 1'b1;
        sp(8'd0, 5'h02);
        chk("diag_length", 32'd16, {24'h0, DIAG_LENGTH});
        chk("preset_sel", 32'h1, {31'h0, PRESET_SELECT});
        wr(`CONFIG_OFS, 32'h0);
        wr(`OUT_DATA_OFS, 32'h1abcdef1);
        wr(`SVC_CTRL_OFS, 32'h0382);
        chk("prog_value", 32'h1abcdef1, {3'h0, PROG_VALUE});
        chk("prog_axis", 32'h7, {28'h0, PROG_AXIS, PROG_SLOT});
        rc("frame12", 8'h4c, 32'hffffffff, 32'hf1debc82);
        wr(`SVC_CTRL_OFS, 32'h0581);
        chk("n_prog", 32'h1, 32'(n_prog));
        rc("frame4", 8'h44, 32'h40000000, 32'h40000000);
        wr(`SVC_CTRL_OFS, 32'h0100);
        rc("frame4", 8'h44, 32'h20000000, 32'h20000000);
        wr(`OUT_DATA_OFS, 32'h00001234);
        wr(`OUT_DATA_OFS, 32'h8abc1234);
        chk("preset_value", 32'h0abc1234, {2'h0, PRESET_VALUE});
        chk("preset_axis", 32'h1, {29'h0, PRESET_AXIS});
        rc("frame8", 8'h48, 32'h00ff0000, 32'h00800000);
        rc("frame4", 8'h44, 32'h40000000, 32'h0);
        wr(`OUT_DATA_OFS, 32'h80000001);
        chk("n_preset", 32'h1, 32'(n_preset));
        wr(`CONFIG_OFS, 32'h2);
        wr(`OUT_DATA_OFS, 32'h0);
        wr(`OUT_DATA_OFS, 32'h8abc1234);
        chk("preset_value", 32'h1234, {2'h0, PRESET_VALUE});
        for (int i = 0; i < 4; i++) begin
            wr(`DISP_BASE_OFS + 8'(4 * i), {8'h0, dw[i]});
        end
        chk("sign", 32'h3, {28'h0, DISPLAY_SIGN_FLAG[3:0]});
        chk("range", 32'h6, {28'h0, DISPLAY_RANGE_ERR[3:0]});
        chk("mag0", 32'h1869f, {12'h0, DISPLAY_MAGNITUDE_BITS[19:0]});
        chk("mag3", 32'hf423f, {12'h0, DISPLAY_MAGNITUDE_BITS[79:60]});
        test_done;
    end
endmodule
